/* logic/uefr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uefr_defines.svh"
// Function
// - buffering bit picks single (0) or double (1) packet buffers, resets 0.
// - single buffering sizes the fifo at 2^(code+3) bytes.
// - double buffering sizes the fifo at 2^(code+4) bytes.
// - four-bit size code, 0 to 15, also caps the largest packet.
// - 13-bit start field in 8-byte units; bits 15:13 reserved.
// - byte start address equals start field times eight.
// - 7-bit target function address; bit 7 reads zero.
module uefr_regs
   import uefr_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [5:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   output logic      [3:0]  ep_sel_out,
   output logic      [4:0]  tx_log2_bytes_out,
   output logic      [15:0] tx_start_bytes_out,
   output logic      [3:0]  tx_max_code_out,
   output logic      [4:0]  rx_log2_bytes_out,
   output logic      [15:0] rx_start_bytes_out,
   output logic      [3:0]  rx_max_code_out,
   output logic      [6:0]  tx_function_address_out,
   output logic      [6:0]  tx_hub_address_out,
   output logic             tx_multi_translator_out
);
   localparam int N = `UEFR_EP_COUNT;

   // ------------------------------------------------------------
   // storage, one copy per endpoint, plus the shared select and read data
   // ------------------------------------------------------------
   uefr_dir_cfg_t  tx_cfg_ff [N];
   uefr_dir_cfg_t  rx_cfg_ff [N];
   logic [6:0]     func_ff   [N];
   logic [7:0]     hub_ff    [N];
   logic [3:0]     ep_sel_ff;
   logic [15:0]    rdata_ff;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
      hit = (a == o);
   endfunction

   wire logic wr_txsz;
   wire logic wr_rxsz;
   wire logic wr_txst;
   wire logic wr_rxst;
   wire logic wr_func;
   wire logic wr_hub;
   wire logic wr_sel;
   assign wr_txsz = wr_in & hit(addr_in, `UEFR_OFF_TX_FIFO_SIZE);
   assign wr_rxsz = wr_in & hit(addr_in, `UEFR_OFF_RX_FIFO_SIZE);
   assign wr_txst = wr_in & hit(addr_in, `UEFR_OFF_TX_FIFO_START);
   assign wr_rxst = wr_in & hit(addr_in, `UEFR_OFF_RX_FIFO_START);
   assign wr_func = wr_in & hit(addr_in, `UEFR_OFF_TX_TARGET_FUNC);
   assign wr_hub  = wr_in & hit(addr_in, `UEFR_OFF_TX_TARGET_HUB);
   assign wr_sel  = wr_in & hit(addr_in, `UEFR_OFF_ENDPOINT_SEL);

   // ------------------------------------------------------------
   // selected endpoint views
   // ------------------------------------------------------------
   wire uefr_dir_cfg_t tx_cur;
   wire uefr_dir_cfg_t rx_cur;
   assign tx_cur = tx_cfg_ff[ep_sel_ff];
   assign rx_cur = rx_cfg_ff[ep_sel_ff];

   // size fields: reserved 15:5 read zero
   wire logic [15:0] txsz_rd;
   wire logic [15:0] rxsz_rd;
   assign txsz_rd = {11'h000, tx_cur.dbl, tx_cur.size_code};
   assign rxsz_rd = {11'h000, rx_cur.dbl, rx_cur.size_code};

   // read mux, unmapped addresses return zero
   logic [15:0] nxt_rdata;
   always_comb begin
      case (addr_in)
         `UEFR_OFF_TX_FIFO_SIZE:   nxt_rdata = txsz_rd;
         `UEFR_OFF_RX_FIFO_SIZE:   nxt_rdata = rxsz_rd;
         `UEFR_OFF_TX_FIFO_START:  nxt_rdata = {3'h0, tx_cur.start};
         `UEFR_OFF_RX_FIFO_START:  nxt_rdata = {3'h0, rx_cur.start};
         `UEFR_OFF_TX_TARGET_FUNC:
            nxt_rdata = {9'h000, func_ff[ep_sel_ff]};
         `UEFR_OFF_TX_TARGET_HUB:  nxt_rdata = {8'h00, hub_ff[ep_sel_ff]};
         `UEFR_OFF_ENDPOINT_SEL:   nxt_rdata = {12'h000, ep_sel_ff};
         default:                  nxt_rdata = 16'h0000;
      endcase
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= rd_in ? nxt_rdata : 16'h0000;
      end
   end
   assign rdata_out = rdata_ff;

   // endpoint select
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ep_sel_ff <= 4'h0;
      end else if (wr_sel) begin
         ep_sel_ff <= wdata_in[`UEFR_EP_BITS-1:0];
      end
   end

   // ------------------------------------------------------------
   // per-endpoint register copies
   // ------------------------------------------------------------
   // the size code is writable here: the buffering read-only marking
   // on it would leave the fifo unsizable, so software programs it
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ep
         wire logic me;
         assign me = (ep_sel_ff == 4'(g));
         always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               tx_cfg_ff[g] <= '{1'b0, 4'h0, `UEFR_RST_START};
               rx_cfg_ff[g] <= '{1'b0, 4'h0, `UEFR_RST_START};
               func_ff[g]   <= `UEFR_RST_ADDR7;
               hub_ff[g]    <= `UEFR_RST_HUB;
            end else begin
               if (wr_txsz && me) begin
                  tx_cfg_ff[g].dbl       <= wdata_in[`UEFR_DBL_BIT];
                  tx_cfg_ff[g].size_code <= wdata_in[3:0];
               end
               if (wr_rxsz && me) begin
                  rx_cfg_ff[g].dbl       <= wdata_in[`UEFR_DBL_BIT];
                  rx_cfg_ff[g].size_code <= wdata_in[3:0];
               end
               if (wr_txst && me) begin
                  tx_cfg_ff[g].start <= wdata_in[12:0];
               end
               if (wr_rxst && me) begin
                  rx_cfg_ff[g].start <= wdata_in[12:0];
               end
               if (wr_func && me) begin
                  func_ff[g] <= wdata_in[6:0];
               end
               if (wr_hub && me) begin
                  hub_ff[g] <= wdata_in[7:0];
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // geometry for the selected endpoint
   // ------------------------------------------------------------
   uefr_cfg_if tx_if ();
   uefr_cfg_if rx_if ();
   assign tx_if.size_reg  = {tx_cur.dbl, tx_cur.size_code};
   assign tx_if.start_reg = tx_cur.start;
   assign rx_if.size_reg  = {rx_cur.dbl, rx_cur.size_code};
   assign rx_if.start_reg = rx_cur.start;

   uefr_geometry u_tx_geo (.cfg(tx_if.calc));
   uefr_geometry u_rx_geo (.cfg(rx_if.calc));

   assign tx_log2_bytes_out  = tx_if.log2_bytes;
   assign tx_start_bytes_out = tx_if.start_bytes;
   assign rx_log2_bytes_out  = rx_if.log2_bytes;
   assign rx_start_bytes_out = rx_if.start_bytes;
   // largest packet code is the size code itself
   assign tx_max_code_out    = tx_cur.size_code;
   assign rx_max_code_out    = rx_cur.size_code;
   assign ep_sel_out         = ep_sel_ff;
   assign tx_function_address_out = func_ff[ep_sel_ff];
   assign tx_hub_address_out      = hub_ff[ep_sel_ff][6:0];
   assign tx_multi_translator_out = hub_ff[ep_sel_ff][`UEFR_MULT_BIT];

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_dbl_exp;
      @(posedge clk_in) disable iff (!reset_n_in)
      tx_log2_bytes_out ==
         5'({1'b0, tx_cur.size_code} + 5'h03 + {4'h0, tx_cur.dbl});
   endproperty
   a_dbl_exp: assert property (p_dbl_exp)
      else $error("tx fifo exponent wrong");

   property p_dbl_more;
      @(posedge clk_in) disable iff (!reset_n_in)
      rx_cur.dbl |-> rx_log2_bytes_out == {1'b0, rx_cur.size_code} + 5'h04;
   endproperty
   a_dbl_more: assert property (p_dbl_more)
      else $error("double buffer size wrong");

   property p_start8;
      @(posedge clk_in) disable iff (!reset_n_in)
      tx_start_bytes_out[2:0] == 3'h0 &&
      tx_start_bytes_out[15:3] == tx_cur.start;
   endproperty
   a_start8: assert property (p_start8)
      else $error("start byte address wrong");

   property p_rsv_sz;
      @(posedge clk_in) disable iff (!reset_n_in)
      $past(rd_in) && $past(addr_in) == `UEFR_OFF_TX_FIFO_SIZE
         |-> rdata_out[15:5] == 11'h000;
   endproperty
   a_rsv_sz: assert property (p_rsv_sz)
      else $error("size reserved bits not zero");

   property p_rsv_func;
      @(posedge clk_in) disable iff (!reset_n_in)
      $past(rd_in) && $past(addr_in) == `UEFR_OFF_TX_TARGET_FUNC
         |-> rdata_out[15:7] == 9'h000;
   endproperty
   a_rsv_func: assert property (p_rsv_func)
      else $error("function reserved bit not zero");

   property p_start_wr;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_txst ##1 !wr_sel |-> tx_cur.start == $past(wdata_in[12:0]);
   endproperty
   a_start_wr: assert property (p_start_wr)
      else $error("start field not written");

   property p_hub_wr;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_hub |=> tx_multi_translator_out == $past(wdata_in[7]);
   endproperty
   a_hub_wr: assert property (p_hub_wr)
      else $error("multi translator bit not written");

   property p_sel_keep;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_sel ##1 (!wr_in)[*2] |-> ep_sel_out == $past(wdata_in[3:0], 2);
   endproperty
   a_sel_keep: assert property (p_sel_keep)
      else $error("endpoint select lost");

   property p_dbl_wr;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_rxsz |=> rx_cur.dbl == $past(wdata_in[4]) &&
                  rx_max_code_out == $past(wdata_in[3:0]);
   endproperty
   a_dbl_wr: assert property (p_dbl_wr)
      else $error("rx size register not written");

   // single tx buffering keeps the exponent at code plus three
   property p_tx_single;
      @(posedge clk_in) disable iff (!reset_n_in)
      !tx_cur.dbl |->
         tx_log2_bytes_out == {1'b0, tx_cur.size_code} + 5'h03;
   endproperty
   a_tx_single: assert property (p_tx_single)
      else $error("tx single buffer size wrong");

   // single rx buffering, same exponent rule as tx
   property p_rx_single;
      @(posedge clk_in) disable iff (!reset_n_in)
      !rx_cur.dbl |->
         rx_log2_bytes_out == {1'b0, rx_cur.size_code} + 5'h03;
   endproperty
   a_rx_single: assert property (p_rx_single)
      else $error("rx single buffer size wrong");

   // double tx buffering takes twice the single allocation
   property p_tx_double;
      @(posedge clk_in) disable iff (!reset_n_in)
      tx_cur.dbl |->
         tx_log2_bytes_out == {1'b0, tx_cur.size_code} + 5'h04;
   endproperty
   a_tx_double: assert property (p_tx_double)
      else $error("tx double buffer size wrong");

   // tx size write lands in the selected copy one cycle later
   property p_txsz_wr;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_txsz |=> tx_cur.dbl == $past(wdata_in[`UEFR_DBL_BIT]) &&
                  tx_max_code_out == $past(wdata_in[`UEFR_SZ_MSB:0]);
   endproperty
   a_txsz_wr: assert property (p_txsz_wr)
      else $error("tx size register not written");

   // function address write, reserved bit 7 dropped
   property p_func_wr;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_func |=>
         tx_function_address_out == $past(wdata_in[`UEFR_ADDR7_MSB:0]);
   endproperty
   a_func_wr: assert property (p_func_wr)
      else $error("function address not written");

   // rx start field reads never show the reserved top bits
   property p_rsv_start;
      @(posedge clk_in) disable iff (!reset_n_in)
      $past(rd_in) && $past(addr_in) == `UEFR_OFF_RX_FIFO_START
         |-> rdata_out[15:13] == 3'h0;
   endproperty
   a_rsv_start: assert property (p_rsv_start)
      else $error("start reserved bits not zero");

   // rx byte start is the field in 8-byte units
   property p_rx_start8;
      @(posedge clk_in) disable iff (!reset_n_in)
      rx_start_bytes_out[2:0] == 3'h0 &&
      rx_start_bytes_out[15:3] == rx_cur.start;
   endproperty
   a_rx_start8: assert property (p_rx_start8)
      else $error("rx start byte address wrong");

   // read data only stands after a read, so stale values cannot leak
   property p_rd_idle;
      @(posedge clk_in) disable iff (!reset_n_in)
      !$past(rd_in) |->
         rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");

   // without a write neither the copy nor the selection may move
   property p_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      !wr_in |=> $stable(tx_start_bytes_out) &&
                 $stable(tx_function_address_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("endpoint copy changed without write");

   // a select write switches the view in the next cycle
   property p_sel_view;
      @(posedge clk_in) disable iff (!reset_n_in)
      wr_sel |=>
         ep_sel_out == $past(wdata_in[`UEFR_EP_BITS-1:0]);
   endproperty
   a_sel_view: assert property (p_sel_view)
      else $error("endpoint select not taken");
endmodule
`default_nettype wire

/* logic/uefr_defines.svh */
`ifndef UEFR_DEFINES_SVH
`define UEFR_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ---------------------------------------------------------------
`define UEFR_OFF_TX_FIFO_SIZE   6'h00
`define UEFR_OFF_RX_FIFO_SIZE   6'h04
`define UEFR_OFF_TX_FIFO_START  6'h08
`define UEFR_OFF_RX_FIFO_START  6'h0C
`define UEFR_OFF_TX_TARGET_FUNC 6'h10
`define UEFR_OFF_TX_TARGET_HUB  6'h14
`define UEFR_OFF_ENDPOINT_SEL   6'h18

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define UEFR_DBL_BIT            4
`define UEFR_SZ_MSB             3
`define UEFR_START_MSB          12
`define UEFR_ADDR7_MSB          6
`define UEFR_MULT_BIT           7
`define UEFR_EP_COUNT           16
`define UEFR_EP_BITS            4

// ---------------------------------------------------------------
// reset values and derived constants
// ---------------------------------------------------------------
`define UEFR_RST_SIZE           5'h00
`define UEFR_RST_START          13'h0000
`define UEFR_RST_ADDR7          7'h00
`define UEFR_RST_HUB            8'h00
`define UEFR_SIZE_BASE_LOG2     5'h03
`define UEFR_START_UNIT_LOG2    3

`endif

/* logic/uefr_pkg.sv */
`default_nettype none
package uefr_pkg;
   // per-endpoint configuration for one direction
   typedef struct packed {
      logic        dbl;
      logic [3:0]  size_code;
      logic [12:0] start;
   } uefr_dir_cfg_t;
endpackage
`default_nettype wire

/* logic/uefr_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface uefr_cfg_if;
   logic [4:0]  size_reg;
   logic [12:0] start_reg;
   logic [4:0]  log2_bytes;
   logic [15:0] start_bytes;
   modport calc (input size_reg, input start_reg,
                 output log2_bytes, output start_bytes);
   modport user (output size_reg, output start_reg,
                 input log2_bytes, input start_bytes);
endinterface
`default_nettype wire

/* logic/uefr_geometry.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uefr_defines.svh"
// ---------------------------------------------------------------
// fifo geometry from size code, buffering mode and start field
// ---------------------------------------------------------------
module uefr_geometry
   import uefr_pkg::*;
(
   uefr_cfg_if.calc  cfg
);
   wire logic       dbl;
   wire logic [3:0] code;
   assign dbl  = cfg.size_reg[`UEFR_DBL_BIT];
   assign code = cfg.size_reg[`UEFR_SZ_MSB:0];
   // exponent: code+3 single, code+4 double
   assign cfg.log2_bytes = {1'b0, code} + `UEFR_SIZE_BASE_LOG2
                           + {4'h0, dbl};
   // byte start address is eight times the field
   assign cfg.start_bytes = {cfg.start_reg,
                             {`UEFR_START_UNIT_LOG2{1'b0}}};
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uefr_defines.svh"
module tb;
   logic        clk_in, reset_n_in, wr_in, rd_in;
   logic [5:0]  addr_in;
   logic [15:0] wdata_in, rdata_out, tx_start_bytes_out, rx_start_bytes_out;
   logic [3:0]  ep_sel_out, tx_max_code_out, rx_max_code_out, cur;
   logic [4:0]  tx_log2_bytes_out, rx_log2_bytes_out;
   logic [6:0]  tx_function_address_out, tx_hub_address_out;
   logic        tx_multi_translator_out;
   logic [4:0]  m_tsz [16], m_rsz [16];
   logic [12:0] m_tst [16], m_rst [16];
   logic [6:0]  m_fn [16];
   logic [7:0]  m_hub [16];
   logic [31:0] seed;
   int          err_count, num_checks;

   uefr_regs DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .ep_sel_out(ep_sel_out),
      .tx_log2_bytes_out(tx_log2_bytes_out),
      .tx_start_bytes_out(tx_start_bytes_out),
      .tx_max_code_out(tx_max_code_out),
      .rx_log2_bytes_out(rx_log2_bytes_out),
      .rx_start_bytes_out(rx_start_bytes_out),
      .rx_max_code_out(rx_max_code_out),
      .tx_function_address_out(tx_function_address_out),
      .tx_hub_address_out(tx_hub_address_out),
      .tx_multi_translator_out(tx_multi_translator_out));

   // ---------------------------------------------------------------
   // helpers: random source, expectations, bus cycles
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // fifo bytes as a power of two: code plus three, one more if doubled
   function automatic logic [4:0] lg(input logic [4:0] s);
      return {1'b0, s[3:0]} + 5'h03 + {4'h0, s[4]};
   endfunction

   task automatic chk(input string n, input logic [15:0] seen,
                      input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one bus cycle; the strobes keep their values after it until the next call sets them
   task automatic bus(input logic w, input logic r, input logic [5:0] a,
                      input logic [15:0] d);
      wr_in <= w;
      rd_in <= r;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      #1;
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e,
                     input string n);
      bus(1'b0, 1'b1, a, 16'h0000);
      chk(n, rdata_out, e);
   endtask

   task automatic sel(input logic [3:0] ep);
      bus(1'b1, 1'b0, `UEFR_OFF_ENDPOINT_SEL, {12'h000, ep});
      cur = ep;
   endtask

   // write a register of the selected endpoint, model keeps legal bits
   task automatic put(input int k, input logic [15:0] d);
      case (k)
         0: begin
            bus(1'b1, 1'b0, `UEFR_OFF_TX_FIFO_SIZE, d);
            m_tsz[cur] = d[4:0];
         end
         1: begin
            bus(1'b1, 1'b0, `UEFR_OFF_RX_FIFO_SIZE, d);
            m_rsz[cur] = d[4:0];
         end
         2: begin
            bus(1'b1, 1'b0, `UEFR_OFF_TX_FIFO_START, d);
            m_tst[cur] = d[12:0];
         end
         3: begin
            bus(1'b1, 1'b0, `UEFR_OFF_RX_FIFO_START, d);
            m_rst[cur] = d[12:0];
         end
         4: begin
            bus(1'b1, 1'b0, `UEFR_OFF_TX_TARGET_FUNC, d);
            m_fn[cur] = d[6:0];
         end
         default: begin
            bus(1'b1, 1'b0, `UEFR_OFF_TX_TARGET_HUB, d);
            m_hub[cur] = d[7:0];
         end
      endcase
   endtask

   // compare every output and every register of the selected endpoint
   task automatic chk_ep();
      chk("ep_sel", {12'h000, ep_sel_out}, {12'h000, cur});
      chk("tx_log2", {11'h000, tx_log2_bytes_out}, {11'h000, lg(m_tsz[cur])});
      chk("rx_log2", {11'h000, rx_log2_bytes_out}, {11'h000, lg(m_rsz[cur])});
      chk("tx_max", {12'h000, tx_max_code_out}, {12'h000, m_tsz[cur][3:0]});
      chk("rx_max", {12'h000, rx_max_code_out}, {12'h000, m_rsz[cur][3:0]});
      chk("tx_start", tx_start_bytes_out, {m_tst[cur], 3'h0});
      chk("rx_start", rx_start_bytes_out, {m_rst[cur], 3'h0});
      chk("func", {9'h000, tx_function_address_out}, {9'h000, m_fn[cur]});
      chk("hub", {8'h00, tx_multi_translator_out, tx_hub_address_out}, {8'h00, m_hub[cur]});
      rd(`UEFR_OFF_TX_FIFO_SIZE, {11'h000, m_tsz[cur]}, "rd_tx_size");
      rd(`UEFR_OFF_RX_FIFO_SIZE, {11'h000, m_rsz[cur]}, "rd_rx_size");
      rd(`UEFR_OFF_TX_FIFO_START, {3'h0, m_tst[cur]}, "rd_tx_start");
      rd(`UEFR_OFF_RX_FIFO_START, {3'h0, m_rst[cur]}, "rd_rx_start");
      rd(`UEFR_OFF_TX_TARGET_FUNC, {9'h000, m_fn[cur]}, "rd_func");
      rd(`UEFR_OFF_TX_TARGET_HUB, {8'h00, m_hub[cur]}, "rd_hub");
      bus(1'b0, 1'b0, 6'h00, 16'h0000);
   endtask

   task automatic clear_model();
      for (int i = 0; i < 16; i++) begin
         m_tsz[i] = 5'h00; m_rsz[i] = 5'h00; m_tst[i] = 13'h0000;
         m_rst[i] = 13'h0000; m_fn[i] = 7'h00; m_hub[i] = 8'h00;
      end
      cur = 4'h0;
   endtask

   // ---------------------------------------------------------------
   // watchdog: no test may run away
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      $display("[ERR] watchdog expected finish seen hang");
      test_done();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      wr_in = 1'b0; rd_in = 1'b0; addr_in = 6'h00; wdata_in = 16'h0000;
      reset_n_in = 1'b0; seed = 32'h0001_8162;
      err_count = 0; num_checks = 0;
      clear_model();
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      #1;
      chk_ep();
      $display("test reset values done");
      // random contents, reserved bits included, one set per endpoint
      for (int e = 0; e < 16; e++) begin
         sel(e[3:0]);
         for (int k = 0; k < 6; k++) begin
            seed = lfsr_step(seed);
            put(k, seed[15:0]);
         end
      end
      for (int e = 15; e >= 0; e--) begin
         sel(e[3:0]);
         chk_ep();
      end
      $display("test per endpoint copies done");
      // every size code in both buffering modes, reserved bits set on tx and clear on rx
      sel(4'h5);
      for (int i = 0; i < 32; i++) begin
         put(0, {11'h7FF, i[4:0]});
         put(1, {11'h000, ~i[4:0]});
         chk_ep();
      end
      $display("test size sweep done");
      // start field limits and address extremes
      put(2, 16'hFFFF); put(3, 16'hE000); put(4, 16'hFFFF); put(5, 16'h0080);
      chk_ep();
      $display("test boundaries done");
      // unmapped access, back to back reads, read data for one cycle only
      bus(1'b1, 1'b0, 6'h1C, 16'hFFFF);
      rd(6'h1C, 16'h0000, "rd_unmapped");
      rd(6'h3C, 16'h0000, "rd_unmapped_hi");
      put(5, 16'h005A);
      rd(`UEFR_OFF_TX_TARGET_HUB, 16'h005A, "rd_hub_b2b");
      bus(1'b0, 1'b0, 6'h00, 16'h0000);
      chk("rdata_idle", rdata_out, 16'h0000);
      chk_ep();
      $display("test unmapped and back to back done");
      // second reset in mid-run clears every endpoint
      sel(4'h9);
      put(0, 16'h001F);
      // drop the strobe first, or the write repeats after release
      bus(1'b0, 1'b0, 6'h00, 16'h0000);
      chk("tx_max_pre", {12'h000, tx_max_code_out}, 16'h000F);
      reset_n_in <= 1'b0;
      @(posedge clk_in);
      @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      #1;
      clear_model();
      chk_ep();
      sel(4'h9);
      chk_ep();
      $display("test mid-run reset done");
      test_done();
   end
endmodule
`default_nettype wire
